// *** hdl/gpc_pkg.sv ***
package gpc_pkg;

    // Port geometry: one slot per pin, eight pins at most.
    localparam int PINS = 8;
    localparam int MODE_W = 3;
    localparam int SEL_W = 4;
    localparam int EDGE_W = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // Register byte offsets on the register bus.
    localparam logic [7:0] OFS_OUT = 8'h00;
    localparam logic [7:0] OFS_IN = 8'h04;
    localparam logic [7:0] OFS_CFG = 8'h08;
    localparam logic [7:0] OFS_CFG_IN = 8'h0c;
    localparam logic [7:0] OFS_EDGE_CFG = 8'h10;
    localparam logic [7:0] OFS_INTR = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_SEL = 8'h1c;
    localparam logic [7:0] OFS_HOLD = 8'h20;

    // Field positions: drive mode of pin i at [3i+2:3i], buffer enables high.
    localparam int CFG_IN_EN_POS = 24;
    localparam int HOLD_POS = 0;

    // Values after reset: every pin undriven with its input buffer off.
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] EDGE_RESET = 16'h0000;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Drive mode encodings.
    typedef enum logic [2:0] {
        DM_HIZ = 3'b000,
        DM_RSVD = 3'b001,
        DM_PULL_UP = 3'b010,
        DM_PULL_DOWN = 3'b011,
        DM_OD_LOW = 3'b100,
        DM_OD_HIGH = 3'b101,
        DM_STRONG = 3'b110,
        DM_PULL_BOTH = 3'b111
    } gpc_drive_mode_t;

    // Edge selection for the pin interrupt.
    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } gpc_edge_t;

    // Bus answer state.
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } gpc_bus_state_t;

    // Source select codes that have a meaning of their own.
    localparam logic [3:0] SEL_REG_FABOE = 4'h1;
    localparam logic [3:0] SEL_FABRIC = 4'h2;
    localparam logic [3:0] SEL_FAB_REGOE = 4'h3;
    localparam logic [3:0] SEL_AMUX_A_FABOE = 4'h6;
    localparam logic [3:0] SEL_AMUX_B_FABOE = 4'h7;
    localparam int SEL_FIXED_BIT = 3;

endpackage

// *** hdl/gpc_drv_if.sv ***
`timescale 1ns/1ps
// Per-pin driver request and decoded output stage.
interface gpc_drv_if;
    import gpc_pkg::*;
    logic [PINS-1:0][MODE_W-1:0] mode;
    logic [PINS-1:0] data;
    logic [PINS-1:0] enable;
    logic [PINS-1:0] fixed;
    logic [PINS-1:0] drv_hi;
    logic [PINS-1:0] drv_lo;
    logic [PINS-1:0] pull_up;
    logic [PINS-1:0] pull_dn;
    modport ctl(output mode, output data, output enable, output fixed,
        input drv_hi, input drv_lo, input pull_up, input pull_dn);
    modport dec(input mode, input data, input enable, input fixed,
        output drv_hi, output drv_lo, output pull_up, output pull_dn);
endinterface

// *** hdl/gpc_drive_decode.sv ***
`timescale 1ns/1ps
module gpc_drive_decode (
    gpc_drv_if.dec drv
);
    import gpc_pkg::*;

    // Result bits are {strong high, strong low, pull up, pull down}.
    function automatic logic [3:0] decode(input logic [2:0] m,
        input logic d, input logic en, input logic ff);
        logic [3:0] r;
        r = 4'h0;
        if (!en) begin
            // A fixed peripheral that releases the pin keeps the resistors.
            if (ff) begin
                case (gpc_drive_mode_t'(m))
                    DM_PULL_UP: r = 4'b0010; // [R12]
                    DM_PULL_DOWN: r = 4'b0001; // [R12]
                    DM_PULL_BOTH: r = 4'b0011; // [R12]
                    default: r = 4'h0;
                endcase
            end
        end else begin
            case (gpc_drive_mode_t'(m))
                DM_HIZ: r = 4'h0; // [R10]
                DM_PULL_UP: r = d ? 4'b0010 : 4'b0100; // [R14]
                DM_PULL_DOWN: r = d ? 4'b1000 : 4'b0001; // [R14]
                DM_OD_LOW: r = d ? 4'b0000 : 4'b0100; // [R13]
                DM_OD_HIGH: r = d ? 4'b1000 : 4'b0000; // [R13]
                DM_PULL_BOTH: r = d ? 4'b0010 : 4'b0001; // [R14]
                default: r = d ? 4'b1000 : 4'b0100; // [R16]
            endcase
        end
        return r;
    endfunction

    // One independent decoder per pin slot.
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            wire [3:0] res;
            assign res = decode(drv.mode[i], drv.data[i], drv.enable[i],
                drv.fixed[i]); // [R9] [R10]
            assign drv.drv_hi[i] = res[3];
            assign drv.drv_lo[i] = res[2];
            assign drv.pull_up[i] = res[1];
            assign drv.pull_dn[i] = res[0];
        end
    endgenerate

endmodule

// *** hdl/gpc_port_cell.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1: One port holds up to eight pins, each with its own field slot.
// R2: Each pin raises an interrupt on rising, falling or either edge.
// R3: Hold freezes pins at their last driven state for deep sleep.
// R4: Per-pin input buffer enable bit in an eight-bit configuration field.
// R5: Input goes to the CPU input register and the selected peripheral.
// R6: Per-pin bit chooses CMOS with two-wire characteristics or TTL trip.
// R7: Output source is CPU registers, fabric or fixed peripherals.
// R8: Driver enable comes from fabric enable or output data register.
// R9: Each pin chooses one of eight drive modes in port configuration.
// R10: Modes: 0 undriven, 2 up, 3 down, 4/5 open drain, 6 strong, 7 both.
// R11: Software should not program the reserved drive mode value one.
// R12: Fixed peripherals get altered behaviour for the same seven modes; here only modes 2, 3 and 7 differ, keeping pulls while the fixed enable is low.
// R13: Open drain leaves one level undriven and drives the other strongly.
// R14: Resistive modes use resistance on one level, both in combined mode.
// R15: After reset every pin is undriven with its input buffer off.
// R16: Strong mode drives the pin high and low from the data value.
// R17: Inputs are synchronised, and selected edges set sticky pending flags.
// R18: Hold latches value, enable and drive mode, ignoring source changes.
module gpc_port_cell (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [gpc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [gpc_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [gpc_pkg::BE_W-1:0] avs_byteenable,
    output logic [gpc_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [gpc_pkg::PINS-1:0] pin_in,
    output logic [gpc_pkg::PINS-1:0] pin_out,
    output logic [gpc_pkg::PINS-1:0] pin_oe,
    output logic [gpc_pkg::PINS-1:0] pin_pull_up,
    output logic [gpc_pkg::PINS-1:0] pin_pull_down,
    output logic [gpc_pkg::PINS-1:0] pin_in_buf_en,
    output logic [gpc_pkg::PINS-1:0] pin_trip_ttl,
    input wire logic [gpc_pkg::PINS-1:0] fabric_out,
    input wire logic [gpc_pkg::PINS-1:0] fabric_oe,
    input wire logic [gpc_pkg::PINS-1:0] fixed_out,
    input wire logic [gpc_pkg::PINS-1:0] fixed_oe,
    output logic [gpc_pkg::PINS-1:0] fabric_in,
    output logic [gpc_pkg::PINS-1:0] fixed_in,
    output logic irq
);
    import gpc_pkg::*;

    // Software-visible state.
    logic [PINS-1:0] out_data;
    logic [DATA_W-1:0] cfg;
    logic [PINS-1:0] cfg_in;
    logic [PINS*EDGE_W-1:0] edge_cfg;
    logic [PINS-1:0] intr;
    logic [PINS-1:0] mask;
    logic [DATA_W-1:0] sel;
    logic hold;

    // Bus answer state.
    gpc_bus_state_t bus_state;
    gpc_bus_state_t next_bus_state;

    // Input synchroniser and edge history.
    logic [PINS-1:0] sync_a;
    logic [PINS-1:0] sync_b;
    logic [PINS-1:0] in_prev;

    // Merge write data into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // True when the select code hands the pin to a fixed peripheral.
    function automatic logic is_fixed(input logic [3:0] s);
        return s[SEL_FIXED_BIT];
    endfunction

    // True when the fabric supplies the output data.
    function automatic logic fab_data(input logic [3:0] s);
        return (s == SEL_FABRIC) || (s == SEL_FAB_REGOE);
    endfunction

    // True when the fabric supplies the driver enable.
    function automatic logic fab_enable(input logic [3:0] s);
        return (s == SEL_REG_FABOE) || (s == SEL_FABRIC) ||
            (s == SEL_AMUX_A_FABOE) || (s == SEL_AMUX_B_FABOE);
    endfunction

    // True when the output data register supplies the driver enable.
    function automatic logic reg_enable(input logic [3:0] s);
        return s == SEL_FAB_REGOE;
    endfunction

    // Edge match for one pin under its two-bit edge selection.
    function automatic logic edge_hit(input logic [1:0] e,
        input logic rise, input logic fall);
        logic r;
        r = 1'b0;
        case (gpc_edge_t'(e))
            EDGE_RISE: r = rise;
            EDGE_FALL: r = fall;
            EDGE_BOTH: r = rise | fall;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // A transfer commits on the edge where waitrequest is seen low.
    wire commit;
    wire do_write;
    wire do_read;
    assign commit = (bus_state == BUS_ACK);
    assign do_write = commit & avs_write;
    assign do_read = commit & avs_read;

    // Write strobes per register.
    wire wr_out;
    wire wr_cfg;
    wire wr_cfg_in;
    wire wr_edge;
    wire wr_mask;
    wire wr_sel;
    wire wr_hold;
    wire rd_intr;
    assign wr_out = do_write && (avs_address == OFS_OUT);
    assign wr_cfg = do_write && (avs_address == OFS_CFG);
    assign wr_cfg_in = do_write && (avs_address == OFS_CFG_IN);
    assign wr_edge = do_write && (avs_address == OFS_EDGE_CFG);
    assign wr_mask = do_write && (avs_address == OFS_MASK);
    assign wr_sel = do_write && (avs_address == OFS_SEL);
    assign wr_hold = do_write && (avs_address == OFS_HOLD);
    assign rd_intr = do_read && (avs_address == OFS_INTR);

    // Merged write values, each cut to its register width.
    wire [31:0] m_out;
    wire [31:0] m_cfg;
    wire [31:0] m_cfg_in;
    wire [31:0] m_edge;
    wire [31:0] m_mask;
    wire [31:0] m_sel;
    wire [31:0] m_hold;
    assign m_out = merge({24'h0, out_data}, avs_writedata, avs_byteenable);
    assign m_cfg = merge(cfg, avs_writedata, avs_byteenable);
    assign m_cfg_in = merge({24'h0, cfg_in}, avs_writedata, avs_byteenable);
    assign m_edge = merge({16'h0, edge_cfg}, avs_writedata, avs_byteenable);
    assign m_mask = merge({24'h0, mask}, avs_writedata, avs_byteenable);
    assign m_sel = merge(sel, avs_writedata, avs_byteenable);
    assign m_hold = merge({31'h0, hold}, avs_writedata, avs_byteenable);

    // Buffer enables and the gated, synchronised input value.
    wire [PINS-1:0] in_en;
    wire [PINS-1:0] in_level;
    wire [PINS-1:0] rise;
    wire [PINS-1:0] fall;
    assign in_en = cfg[CFG_IN_EN_POS +: PINS]; // [R4]
    assign in_level = sync_b & in_en; // [R4] [R17]
    assign rise = in_level & ~in_prev; // [R17]
    assign fall = ~in_level & in_prev; // [R17]

    // Edge events per pin.
    logic [PINS-1:0] hits;
    always_comb begin
        hits = '0;
        for (int i = 0; i < PINS; i++) begin
            hits[i] = edge_hit(edge_cfg[EDGE_W*i +: EDGE_W], rise[i],
                fall[i]); // [R2]
        end
    end

    // Only the bits reported by this read are cleared, so an edge that
    // lands between the report and the commit survives; a set always wins.
    wire [PINS-1:0] intr_clear;
    wire [PINS-1:0] next_intr;
    assign intr_clear = rd_intr ? avs_readdata[PINS-1:0] : '0;
    assign next_intr = (intr & ~intr_clear) | hits; // [R17]

    // Read data selection by address.
    logic [DATA_W-1:0] rd_value;
    always_comb begin
        rd_value = WORD_ZERO;
        if (avs_address == OFS_OUT) begin
            rd_value = {24'h0, out_data};
        end else if (avs_address == OFS_IN) begin
            rd_value = {24'h0, in_level}; // [R5]
        end else if (avs_address == OFS_CFG) begin
            rd_value = cfg;
        end else if (avs_address == OFS_CFG_IN) begin
            rd_value = {24'h0, cfg_in};
        end else if (avs_address == OFS_EDGE_CFG) begin
            rd_value = {16'h0, edge_cfg};
        end else if (avs_address == OFS_INTR) begin
            rd_value = {24'h0, intr};
        end else if (avs_address == OFS_MASK) begin
            rd_value = {24'h0, mask};
        end else if (avs_address == OFS_SEL) begin
            rd_value = sel;
        end else if (avs_address == OFS_HOLD) begin
            rd_value = {31'h0, hold};
        end
    end

    // Source selection per pin towards the drive decoder.
    gpc_drv_if drv();
    logic [PINS-1:0] src_data;
    logic [PINS-1:0] src_en;
    logic [PINS-1:0] src_fixed;
    always_comb begin
        src_data = '0;
        src_en = '0;
        src_fixed = '0;
        for (int i = 0; i < PINS; i++) begin
            if (is_fixed(sel[SEL_W*i +: SEL_W])) begin
                src_data[i] = fixed_out[i]; // [R7]
                src_en[i] = fixed_oe[i]; // [R7]
                src_fixed[i] = 1'b1; // [R12]
            end else begin
                src_data[i] = fab_data(sel[SEL_W*i +: SEL_W]) ?
                    fabric_out[i] : out_data[i]; // [R7]
                if (fab_enable(sel[SEL_W*i +: SEL_W])) begin
                    src_en[i] = fabric_oe[i]; // [R8]
                end else if (reg_enable(sel[SEL_W*i +: SEL_W])) begin
                    src_en[i] = out_data[i]; // [R8]
                end else begin
                    src_en[i] = 1'b1;
                end
            end
        end
    end

    // Per-pin drive mode slots feed the decoder.
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_mode
            assign drv.mode[g] = cfg[MODE_W*g +: MODE_W]; // [R1] [R9]
        end
    endgenerate
    assign drv.data = src_data;
    assign drv.enable = src_en;
    assign drv.fixed = src_fixed;

    // Output stage decoder, one slot per pin.
    gpc_drive_decode u_decode (
        .drv(drv.dec)
    );

    // Input routing to the peripheral picked by the select field.
    logic [PINS-1:0] route_fabric;
    logic [PINS-1:0] route_fixed;
    always_comb begin
        route_fabric = '0;
        route_fixed = '0;
        for (int i = 0; i < PINS; i++) begin
            route_fixed[i] = is_fixed(sel[SEL_W*i +: SEL_W]) &
                in_level[i]; // [R5]
            route_fabric[i] = fab_data(sel[SEL_W*i +: SEL_W]) &
                in_level[i]; // [R5]
        end
    end

    // Bus state: one cycle of waitrequest low per request.
    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_bus_state = BUS_ACK;
                end
            end
            BUS_ACK: next_bus_state = BUS_IDLE;
            default: next_bus_state = BUS_IDLE;
        endcase
    end

    // Answer registers; read data is captured one edge before the commit.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_state <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= WORD_ZERO;
        end else begin
            bus_state <= next_bus_state;
            avs_waitrequest <= (next_bus_state != BUS_ACK);
            if (bus_state == BUS_IDLE && avs_read) begin
                avs_readdata <= rd_value;
            end
        end
    end

    // Configuration registers.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_data <= BYTE_RESET;
            cfg <= CFG_RESET; // [R15]
            cfg_in <= BYTE_RESET;
            edge_cfg <= EDGE_RESET;
        end else begin
            if (wr_out) out_data <= m_out[PINS-1:0];
            if (wr_cfg) cfg <= m_cfg; // [R4] [R9]
            if (wr_cfg_in) cfg_in <= m_cfg_in[PINS-1:0]; // [R6]
            if (wr_edge) edge_cfg <= m_edge[PINS*EDGE_W-1:0]; // [R2]
        end
    end

    // Select, mask and hold control.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel <= SEL_RESET;
            mask <= BYTE_RESET;
            hold <= 1'b0;
        end else begin
            if (wr_sel) sel <= m_sel; // [R7]
            if (wr_mask) mask <= m_mask[PINS-1:0];
            if (wr_hold) hold <= m_hold[HOLD_POS]; // [R3]
        end
    end

    // Two-flop synchroniser; the first stage feeds only the second.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_a <= '0;
            sync_b <= '0;
            in_prev <= '0;
        end else begin
            sync_a <= pin_in; // [R17]
            sync_b <= sync_a; // [R17]
            in_prev <= in_level;
        end
    end

    // Sticky pending flags and the level interrupt.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            intr <= BYTE_RESET;
            irq <= 1'b0;
        end else begin
            intr <= next_intr; // [R17]
            irq <= |(next_intr & mask); // [R2]
        end
    end

    // Pin drivers. Hold freezes value, enable and mode as driven before,
    // so a source that drops out in deep sleep cannot glitch the pin.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_out <= '0; // [R15]
            pin_oe <= '0; // [R15]
            pin_pull_up <= '0; // [R15]
            pin_pull_down <= '0; // [R15]
        end else if (!hold) begin // [R3] [R18]
            pin_out <= drv.drv_hi;
            pin_oe <= drv.drv_hi | drv.drv_lo;
            pin_pull_up <= drv.pull_up;
            pin_pull_down <= drv.pull_dn;
        end
    end

    // Input buffer controls and peripheral input routing.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_in_buf_en <= '0; // [R15]
            pin_trip_ttl <= '0;
            fabric_in <= '0;
            fixed_in <= '0;
        end else begin
            pin_in_buf_en <= in_en; // [R4]
            pin_trip_ttl <= cfg_in; // [R6]
            fabric_in <= route_fabric; // [R5]
            fixed_in <= route_fixed; // [R5]
        end
    end

endmodule

// *** tb/gpc_port_cell_sva.sv ***
`timescale 1ns/1ps
module gpc_port_cell_sva
    import gpc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [gpc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [gpc_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [gpc_pkg::BE_W-1:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic [gpc_pkg::PINS-1:0] pin_in,
    input wire logic [gpc_pkg::PINS-1:0] pin_out,
    input wire logic [gpc_pkg::PINS-1:0] pin_oe,
    input wire logic [gpc_pkg::PINS-1:0] pin_pull_up,
    input wire logic [gpc_pkg::PINS-1:0] pin_pull_down,
    input wire logic [gpc_pkg::PINS-1:0] pin_in_buf_en,
    input wire logic [gpc_pkg::PINS-1:0] pin_trip_ttl,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Bus commits, used as causes below.
    logic req, commit, cfg_wr, cfg_in_wr, mask_wr, intr_rd, hold_wr, hold_q;
    assign req = avs_read || avs_write;
    assign commit = req && !avs_waitrequest;
    assign cfg_wr = commit && avs_write && avs_address == OFS_CFG;
    assign cfg_in_wr = commit && avs_write && avs_address == OFS_CFG_IN;
    assign mask_wr = commit && avs_write && avs_address == OFS_MASK;
    assign intr_rd = commit && avs_read && avs_address == OFS_INTR;
    assign hold_wr = commit && avs_write && avs_address == OFS_HOLD;

    // Copy of the hold bit, to judge freezing at the pins.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_q <= 1'b0;
        end else if (hold_wr && avs_byteenable[0]) begin
            hold_q <= avs_writedata[HOLD_POS];
        end
    end

    sequence req_idle_s;
        req && avs_waitrequest;
    endsequence
    sequence answer_s;
        ##[1:2] !avs_waitrequest;
    endsequence

    wait_bound_a: assert property (req_idle_s |-> answer_s)
        else $error("Request unanswered");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Waitrequest low twice");
    idle_wait_a: assert property (!req |=> avs_waitrequest)
        else $error("Unasked answer");
    buf_en_a: assert property ($changed(pin_in_buf_en) |->
        $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("Buffer enable moved");
    trip_sel_a: assert property ($changed(pin_trip_ttl) |->
        $past(cfg_in_wr) || $past(cfg_in_wr, 2))
        else $error("Threshold moved");
    irq_fall_a: assert property ($fell(irq) |->
        $past(intr_rd) || $past(intr_rd, 2) || $past(mask_wr) ||
        $past(mask_wr, 2))
        else $error("Irq fell unasked");
    irq_rise_a: assert property ($rose(irq) |->
        $past(mask_wr) || $past(mask_wr, 2) || $past(cfg_wr, 2) ||
        $past(pin_in, 3) != $past(pin_in, 4) ||
        $past(pin_in, 4) != $past(pin_in, 5))
        else $error("Irq rose unasked");
    hold_freeze_a: assert property (hold_q && $past(hold_q) |->
        $stable({pin_out, pin_oe, pin_pull_up, pin_pull_down}))
        else $error("Pin moved while held");
    reset_state_a: assert property ($rose(resetn) |-> !irq &&
        (pin_oe | pin_pull_up | pin_pull_down | pin_in_buf_en) == 8'h00)
        else $error("Pins busy after reset");
    drive_excl_a: assert property (
        (pin_oe & (pin_pull_up | pin_pull_down)) == 8'h00)
        else $error("Drive and pull at once");
endmodule

bind gpc_port_cell gpc_port_cell_sva u_gpc_port_cell_sva (.*);

// *** tb/gpc_pin_env.sv ***
`timescale 1ns/1ps
// Board side: external driver, device drive and pulls resolve per pin.
module gpc_pin_env (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pull_up,
    input wire logic [7:0] pin_pull_down,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    logic [7:0] last = 8'h00;

    // A floating pin flips each cycle, never passing for a level.
    always @(posedge clk) begin
        last <= pin_in;
    end

    // Strong drive wins, then the external driver, then the pulls.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pin_pull_up[i] || pin_pull_down[i]) begin
                pin_in[i] = pin_pull_up[i];
            end else begin
                pin_in[i] = ~last[i];
            end
        end
    end
endmodule

// *** tb/gpc_port_cell_test.sv ***
`timescale 1ns/1ps
module gpc_port_cell_test;
    import gpc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = 32'h0;
    logic [BE_W-1:0] avs_byteenable = 4'hf;
    logic [DATA_W-1:0] avs_readdata, rd;
    logic avs_waitrequest, irq;
    logic [PINS-1:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down;
    logic [PINS-1:0] pin_in_buf_en, pin_trip_ttl, fabric_in, fixed_in;
    logic [PINS-1:0] fabric_out = 8'h00, fabric_oe = 8'h00;
    logic [PINS-1:0] fixed_out = 8'h00, fixed_oe = 8'h00;
    logic [PINS-1:0] ext_en = 8'h00, ext_val = 8'h00;
    int err_total = 0, checks_done = 0;
    // Rows: mode, data, expected {strong, high, pull-up, pull-down}.
    logic [7:0] rows [16] = '{8'h00, 8'h10, 8'h28, 8'h3c, 8'h48, 8'h52,
        8'h61, 8'h7c, 8'h88, 8'h90, 8'ha0, 8'hbc, 8'hc8, 8'hdc, 8'he1,
        8'hf2};

    // 100 MHz clock.
    initial begin
        forever #5 clk = ~clk;
    end

    gpc_port_cell u_gpc_port_cell (.*);
    gpc_pin_env u_gpc_pin_env (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One transfer, held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // A value read at an edge was launched one edge before.
    task automatic pins(input logic [31:0] e);
        repeat (2) @(posedge clk);
        chk({pin_oe, pin_oe & pin_out, pin_pull_up, pin_pull_down}, e);
    endtask

    task automatic src(input logic [31:0] s, input logic [31:0] e);
        wr(OFS_SEL, s);
        pins(e);
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Far beyond the few hundred cycles the run needs.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("Error at %0t: timeout", $time);
        tally_and_finish;
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        pins(32'h0);
        chk({24'h0, pin_in_buf_en}, 32'h0);
        rdchk(OFS_CFG, 32'h0);
        rdchk(8'hfc, 32'h0);
        $display("Test reset done");
        foreach (rows[i]) begin
            wr(OFS_CFG, {8'h00, {8{rows[i][7:5]}}});
            wr(OFS_OUT, {24'h0, {8{rows[i][4]}}});
            pins({{8{rows[i][3]}}, {8{rows[i][2]}}, {8{rows[i][1]}},
                {8{rows[i][0]}}});
        end
        $display("Test drive modes done");
        wr(OFS_CFG, 32'h00db_6db6);
        wr(OFS_OUT, 32'hf0);
        fabric_out <= 8'h5a;
        fabric_oe <= 8'h0f;
        fixed_out <= 8'h33;
        fixed_oe <= 8'h0f;
        src(32'h2222_2222, 32'h0f0a_0000);
        src(32'h3333_3333, 32'hf050_0000);
        src(32'h1111_1111, 32'h0f00_0000);
        src(32'h8888_8888, 32'h0f03_0000);
        fixed_oe <= 8'h00;
        src(32'h8888_8888, 32'h0);
        src(32'h0, 32'hfff0_0000);
        $display("Test sources done");
        wr(OFS_HOLD, 32'h1);
        wr(OFS_OUT, 32'h0f);
        wr(OFS_CFG, 32'h0000_0006);
        pins(32'hfff0_0000);
        wr(OFS_HOLD, 32'h0);
        pins(32'h0101_0000);
        $display("Test hold done");
        ext_en <= 8'hff;
        wr(OFS_CFG, 32'ha500_0000);
        ext_val <= 8'h3c;
        wr(OFS_CFG_IN, 32'h3c);
        repeat (4) @(posedge clk);
        chk({24'h0, pin_in_buf_en}, 32'ha5);
        chk({24'h0, pin_trip_ttl}, 32'h3c);
        rdchk(OFS_IN, 32'h24);
        wr(OFS_SEL, 32'h8888_2222);
        repeat (2) @(posedge clk);
        chk({24'h0, fabric_in}, 32'h04);
        chk({24'h0, fixed_in}, 32'h20);
        wr(OFS_SEL, 32'h0);
        $display("Test inputs done");
        ext_val <= 8'h00;
        wr(OFS_CFG, 32'hff00_0000);
        wr(OFS_EDGE_CFG, 32'h39);
        bus(1'b0, OFS_INTR, 32'h0);
        ext_val <= 8'hff;
        repeat (6) @(posedge clk);
        ext_val <= 8'h00;
        repeat (6) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_MASK, 32'h02);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rdchk(OFS_INTR, 32'h07);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rdchk(OFS_INTR, 32'h0);
        $display("Test interrupts done");
        resetn <= 1'b0;
        pins(32'h0);
        chk({24'h0, pin_in_buf_en}, 32'h0);
        resetn <= 1'b1;
        rdchk(OFS_CFG, 32'h0);
        $display("Test second reset done");
        tally_and_finish;
    end
endmodule
